// [core/iwd_pkg.sv]
// constants shared by the inside-window event detector
package iwd_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W   = 12;
  localparam int DB_W     = 8;
  localparam int NUM_AXES = 3;
  localparam int APB_AW   = 8;
  localparam int APB_DW   = 32;
  localparam int REG_W    = 8;
  localparam int IDX_LSB  = 2;

  typedef logic [APB_AW-IDX_LSB-1:0] iwd_idx_t;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam iwd_idx_t IDX_STATUS   = 6'h2E;
  localparam iwd_idx_t IDX_CFG_A    = 6'h2F;
  localparam iwd_idx_t IDX_CFG_B    = 6'h30;
  localparam iwd_idx_t IDX_UPPER    = 6'h31;
  localparam iwd_idx_t IDX_LOWER    = 6'h32;
  localparam iwd_idx_t IDX_DBCNT    = 6'h33;
  localparam iwd_idx_t IDX_IRQ_STAT = 6'h34;
  localparam iwd_idx_t IDX_IRQ_MASK = 6'h35;

  // ---------------------------------------------------------------
  // field positions; axis 0 is z, 1 is y, 2 is x
  // ---------------------------------------------------------------
  localparam int STAT_EA_BIT            = 7;
  localparam int STAT_AXIS_BIT [3]      = '{1, 3, 5};
  localparam int CFG_A_LATCH_BIT        = 6;
  localparam int CFG_A_EN_LSB           = 0;
  localparam int CFG_B_LOGIC_BIT        = 0;
  localparam int CFG_B_WAKE_BIT         = 1;
  localparam int CFG_B_ROUTE_BIT        = 2;
  localparam int IRQ_RISE_BIT           = 0;
  localparam int IRQ_FALL_BIT           = 1;

  // ---------------------------------------------------------------
  // writable masks and reset values
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0]  CFG_A_MASK    = 8'h47;
  localparam logic [REG_W-1:0]  CFG_B_MASK    = 8'h07;
  localparam logic [REG_W-1:0]  IRQ_MASK_BITS = 8'h03;
  localparam logic [REG_W-1:0]  REG_RST       = 8'h00;
  localparam logic [DATA_W-1:0] THR_RST       = 12'h000;
  localparam logic [DB_W-1:0]   DBCNT_RST     = 8'h00;

endpackage

// [core/iwd_axis_cmp.sv]
// strict window comparison for one axis
`timescale 1ns/1ps
`default_nettype none

module iwd_axis_cmp #(
  parameter int W = 12
) (
  // sample and thresholds
  input  wire logic signed [W-1:0] i_value,
  input  wire logic signed [W-1:0] i_upper,
  input  wire logic signed [W-1:0] i_lower,
  // result
  output logic                     o_inside
);

  // strict comparison
  // equal to either threshold counts as outside
  assign o_inside = (i_value > i_lower) && (i_value < i_upper);

endmodule

`default_nettype wire

// [core/iwd_debounce.sv]
// sample counter for the inside condition
`timescale 1ns/1ps
`default_nettype none

module iwd_debounce #(
  parameter int DB_W = 8
) (
  // clock and reset
  input  wire logic            i_core_clk,
  input  wire logic            i_nrst,
  // per-sample condition
  input  wire logic            i_sample,
  input  wire logic            i_cond,
  input  wire logic [DB_W-1:0] i_count,
  // condition held long enough this sample
  output logic                 o_reached
);

  logic [DB_W-1:0] held;
  logic [DB_W-1:0] next_held;

  // saturate so a long hold never wraps back below the count
  always_comb begin
    if (!i_cond) begin
      next_held = '0;
    end else if (&held) begin
      next_held = held;
    end else begin
      next_held = held + 1'b1;
    end
  end

  assign o_reached = i_cond && (next_held >= i_count);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      held <= '0;
    end else if (i_sample) begin
      held <= next_held;
    end
  end

  AST_CNT_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_sample && !i_cond) |=> (held == '0))
    else $error("debounce count not cleared on false condition");

endmodule

`default_nettype wire

// [core/iwd_top.sv]
// inside-window event detector with apb registers
`timescale 1ns/1ps
`default_nettype none

module iwd_top (
  // clock, reset, enable
  input  wire logic                                i_core_clk,
  input  wire logic                                i_nrst,
  input  wire logic                                i_clk_en,
  // apb slave
  input  wire logic                                i_psel,
  input  wire logic                                i_penable,
  input  wire logic                                i_pwrite,
  input  wire logic [iwd_pkg::APB_AW-1:0]          i_paddr,
  input  wire logic [iwd_pkg::APB_DW-1:0]          i_pwdata,
  output logic      [iwd_pkg::APB_DW-1:0]          o_prdata,
  output logic                                     o_pready,
  output logic                                     o_pslverr,
  // sensor samples, one strobe per output sample rate period
  input  wire logic                                i_sample_valid,
  input  wire logic signed [iwd_pkg::DATA_W-1:0]   i_x_data,
  input  wire logic signed [iwd_pkg::DATA_W-1:0]   i_y_data,
  input  wire logic signed [iwd_pkg::DATA_W-1:0]   i_z_data,
  // event outputs
  output logic                                     o_interrupt_pin_a,
  output logic                                     o_interrupt_pin_b,
  output logic                                     o_wake_timer_reset,
  output logic                                     o_irq
);
  import iwd_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic        [REG_W-1:0]    cfg_a;
  logic        [REG_W-1:0]    cfg_b;
  logic        [DB_W-1:0]     dbcnt;
  logic        [REG_W-1:0]    irq_stat;
  logic        [REG_W-1:0]    irq_mask;
  logic        [REG_W-1:0]    next_irq_stat;
  logic signed [DATA_W-1:0]   upper_threshold;
  logic signed [DATA_W-1:0]   lower_threshold;
  logic signed [DATA_W-1:0]   axis_data [NUM_AXES];
  logic        [NUM_AXES-1:0] inside_raw;
  logic        [NUM_AXES-1:0] axis_en;
  logic        [NUM_AXES-1:0] inside_axis;
  logic        [NUM_AXES-1:0] axis_flag;
  logic        [REG_W-1:0]    status_val;
  logic        [REG_W-1:0]    rd_val;
  logic                       rd_mapped;
  logic                       cond;
  logic                       reached;
  logic                       event_active;
  logic                       event_prev;
  logic                       armed;
  logic                       latch_en;
  logic                       samp;
  logic                       access;
  logic                       fire;
  logic                       wr;
  logic                       status_rd;
  logic                       clear_req;
  logic                       latch_set;
  iwd_idx_t                   idx;

  // ---------------------------------------------------------------
  // per-axis comparison
  // ---------------------------------------------------------------
  assign axis_data[0] = i_z_data;
  assign axis_data[1] = i_y_data;
  assign axis_data[2] = i_x_data;

  generate
    for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
      iwd_axis_cmp #(.W(DATA_W)) u_cmp (
        .i_value  (axis_data[g]),
        .i_upper  (upper_threshold),
        .i_lower  (lower_threshold),
        .o_inside (inside_raw[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // inside condition
  // ---------------------------------------------------------------
  assign samp     = i_clk_en & i_sample_valid;
  assign latch_en = cfg_a[CFG_A_LATCH_BIT];

  always_comb begin
    axis_en     = cfg_a[CFG_A_EN_LSB +: NUM_AXES];
    inside_axis = inside_raw & axis_en;
    if (axis_en == '0) begin
      cond = 1'b0;
    end else if (cfg_b[CFG_B_LOGIC_BIT]) begin
      cond = |inside_axis;
    end else begin
      cond = &(inside_raw | ~axis_en);
    end
  end

  iwd_debounce #(.DB_W(DB_W)) u_db (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_sample   (samp),
    .i_cond     (cond),
    .i_count    (dbcnt),
    .o_reached  (reached)
  );

  // ---------------------------------------------------------------
  // apb decode; one wait state, commit on the pready edge
  // ---------------------------------------------------------------
  assign idx       = i_paddr[APB_AW-1:IDX_LSB];
  assign access    = i_clk_en & i_psel & i_penable & ~o_pready;
  assign fire      = i_clk_en & i_psel & i_penable & o_pready;
  assign wr        = fire & i_pwrite;
  assign status_rd = fire & ~i_pwrite & (idx == IDX_STATUS);
  assign clear_req = status_rd & latch_en;
  assign latch_set = samp & reached & armed;

  always_comb begin
    status_val              = '0;
    status_val[STAT_EA_BIT] = event_active;
    for (int i = 0; i < NUM_AXES; i++) begin
      status_val[STAT_AXIS_BIT[i]] = axis_flag[i];
    end
  end

  // read mux
  always_comb begin
    rd_mapped = 1'b1;
    case (idx)
      IDX_STATUS:   rd_val = status_val;
      IDX_CFG_A:    rd_val = cfg_a;
      IDX_CFG_B:    rd_val = cfg_b;
      IDX_UPPER:    rd_val = REG_W'(upper_threshold[DATA_W-1 -: REG_W]);
      IDX_LOWER:    rd_val = REG_W'(lower_threshold[DATA_W-1 -: REG_W]);
      IDX_DBCNT:    rd_val = dbcnt;
      IDX_IRQ_STAT: rd_val = irq_stat;
      IDX_IRQ_MASK: rd_val = irq_mask;
      default: begin
        rd_val    = '0;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // answer registered during the wait state
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      o_pready  <= access;
      o_prdata  <= access ? APB_DW'(rd_val) : '0;
      o_pslverr <= access & ~rd_mapped;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // cfg_a, cfg_b, debounce count and interrupt mask writes
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_a    <= REG_RST;
      cfg_b    <= REG_RST;
      dbcnt    <= DBCNT_RST;
      irq_mask <= REG_RST;
    end else if (wr) begin
      case (idx)
        IDX_CFG_A:    cfg_a    <= i_pwdata[REG_W-1:0] & CFG_A_MASK;
        IDX_CFG_B:    cfg_b    <= i_pwdata[REG_W-1:0] & CFG_B_MASK;
        IDX_DBCNT:    dbcnt    <= i_pwdata[DB_W-1:0];
        IDX_IRQ_MASK: irq_mask <= i_pwdata[REG_W-1:0] & IRQ_MASK_BITS;
        default: ;
      endcase
    end
  end

  // thresholds take the top byte; low bits stay zero for 8-bit steps
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      upper_threshold <= THR_RST;
      lower_threshold <= THR_RST;
    end else if (wr && idx == IDX_UPPER) begin
      upper_threshold <= {i_pwdata[REG_W-1:0], {(DATA_W-REG_W){1'b0}}};
    end else if (wr && idx == IDX_LOWER) begin
      lower_threshold <= {i_pwdata[REG_W-1:0], {(DATA_W-REG_W){1'b0}}};
    end
  end

  // ---------------------------------------------------------------
  // event flag and axis flags
  // ---------------------------------------------------------------
  // rearm only once the condition went false
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      armed <= 1'b1;
    end else if (samp) begin
      armed <= !cond || (armed && !reached);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      event_active <= 1'b0;
    end else if (latch_en) begin
      // set wins over a status read in the same cycle
      if (latch_set) begin
        event_active <= 1'b1;
      end else if (clear_req) begin
        event_active <= 1'b0;
      end
    end else if (samp) begin
      event_active <= reached;
    end
  end

  // latched: capture on rise, clear on read; else copy on reached or zero count
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      axis_flag <= '0;
    end else if (latch_en) begin
      if (latch_set) begin
        axis_flag <= inside_axis;
      end else if (clear_req) begin
        axis_flag <= '0;
      end
    end else if (samp && (reached || dbcnt == '0)) begin
      axis_flag <= inside_axis;
    end
  end

  // ---------------------------------------------------------------
  // wake timer, pins, interrupt
  // ---------------------------------------------------------------
  // wake pulse and pin routing
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wake_timer_reset <= 1'b0;
      o_interrupt_pin_a  <= 1'b0;
      o_interrupt_pin_b  <= 1'b0;
    end else if (i_clk_en) begin
      o_wake_timer_reset <= samp & event_active & cfg_b[CFG_B_WAKE_BIT];
      o_interrupt_pin_a  <= event_active & ~cfg_b[CFG_B_ROUTE_BIT];
      o_interrupt_pin_b  <= event_active & cfg_b[CFG_B_ROUTE_BIT];
    end
  end

  // sticky events, write one to clear, new event wins
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr && idx == IDX_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~i_pwdata[REG_W-1:0];
    end
    next_irq_stat[IRQ_RISE_BIT] = next_irq_stat[IRQ_RISE_BIT] | (event_active & ~event_prev);
    next_irq_stat[IRQ_FALL_BIT] = next_irq_stat[IRQ_FALL_BIT] | (~event_active & event_prev);
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      event_prev <= 1'b0;
      irq_stat   <= REG_RST;
      o_irq      <= 1'b0;
    end else if (i_clk_en) begin
      event_prev <= event_active;
      irq_stat   <= next_irq_stat;
      o_irq      <= |(next_irq_stat & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_latched_read;
    clear_req && !latch_set;
  endsequence

  sequence s_route_a_held;
    (event_active && !cfg_b[CFG_B_ROUTE_BIT] && i_clk_en) [*2];
  endsequence

  AST_EA_AFTER_DEBOUNCE: assert property ($rose(event_active) |-> $past(samp && reached))
    else $error("event flag rose without debounce reached");

  AST_DISABLED_OFF: assert property ((samp && axis_en == '0 && !latch_en) |=> !event_active)
    else $error("event flag set with no axis enabled");

  AST_WAKE_PULSE: assert property ((samp && event_active && cfg_b[CFG_B_WAKE_BIT])
    |=> o_wake_timer_reset)
    else $error("wake timer not reset while event set");

  AST_WAKE_CAUSE: assert property (o_wake_timer_reset |-> $past(event_active && samp))
    else $error("wake timer reset without event");

  AST_READ_CLEARS: assert property (s_latched_read |=> (!event_active && axis_flag == '0))
    else $error("status read did not clear latched flags");

  AST_LATCH_HOLDS: assert property ((latch_en && event_active && !status_rd && !wr)
    |=> event_active)
    else $error("latched event dropped without a status read");

  AST_REARM_NEEDED: assert property (($rose(event_active) && $past(latch_en)) |-> $past(armed))
    else $error("latched event rose without a false condition first");

  AST_FLAGS_REACHED: assert property ((samp && !latch_en && reached && !wr)
    |=> axis_flag == $past(inside_axis))
    else $error("axis flags not updated on reached count");

  AST_FLAGS_ZERO_COUNT: assert property ((samp && !latch_en && dbcnt == '0 && !wr)
    |=> axis_flag == $past(inside_axis))
    else $error("axis flags not updated with zero count");

  AST_STATUS_RESERVED: assert property ((o_pready && !i_pwrite && idx == IDX_STATUS)
    |-> (o_prdata[6] == 1'b0 && o_prdata[4] == 1'b0 && o_prdata[2] == 1'b0
         && o_prdata[0] == 1'b0))
    else $error("reserved status bits not zero");

  AST_PIN_A_ROUTE: assert property (s_route_a_held |-> (o_interrupt_pin_a && !o_interrupt_pin_b))
    else $error("event not routed to pin a");

  AST_INSIDE_STRICT: assert property (inside_axis[0]
    |-> (i_z_data > lower_threshold && i_z_data < upper_threshold))
    else $error("z flagged inside at or beyond a threshold");

endmodule

`default_nettype wire

// [verif/iwd_host_model.sv]
// apb host model that reads and writes the detector registers
`timescale 1ns/1ps
`default_nettype none

module iwd_host_model (
  // clock
  input  wire logic                       i_core_clk,
  // apb answer
  input  wire logic [iwd_pkg::APB_DW-1:0] i_prdata,
  input  wire logic                       i_pready,
  input  wire logic                       i_pslverr,
  // apb request
  output logic                            o_psel,
  output logic                            o_penable,
  output logic                            o_pwrite,
  output logic [iwd_pkg::APB_AW-1:0]      o_paddr,
  output logic [iwd_pkg::APB_DW-1:0]      o_pwdata
);
  import iwd_pkg::*;

  // idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
  end

  // setup, then access until ready; no fixed wait is assumed
  // whole status word kept from the read that clears it
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge i_core_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= wd;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge i_core_clk);
      ok = (i_pready === 1'b1);
    end
    rd = i_prdata;
    err = i_pslverr;
    // released lines show the inverse so stale data never looks valid
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the inside-window event detector
`timescale 1ns/1ps
`default_nettype none

module tb;
  import iwd_pkg::*;

  // ---------------------------------------------------------------
  // signals, rows and instances
  // ---------------------------------------------------------------
  typedef struct {
    logic [7:0]  cfg_a;
    logic [7:0]  cfg_b;
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [7:0]  stat;
  } iwd_row_s;

  localparam logic [11:0] IN  = 12'h000;
  localparam logic [11:0] OUT = 12'h100;

  logic        core_clk = 1'b0;
  logic        nrst;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sv;
  logic [11:0] xd;
  logic [11:0] yd;
  logic [11:0] zd;
  logic        pin_a;
  logic        pin_b;
  logic        wake;
  logic        irq;
  int          fails = 0;
  int          total_checks = 0;
  int          wakes = 0;

  // window is -256..256 exclusive; count zero so flags follow every sample
  iwd_row_s rows [9] = '{
    '{8'h07, 8'h00, 12'h000, 12'h000, 12'h000, 8'hAA},
    '{8'h07, 8'h00, 12'h100, 12'h000, 12'h000, 8'h0A},
    '{8'h07, 8'h00, 12'h0FF, 12'hF01, 12'h000, 8'hAA},
    '{8'h07, 8'h00, 12'h000, 12'h000, 12'hF00, 8'h28},
    '{8'h07, 8'h01, 12'h100, 12'h12C, 12'hF01, 8'h82},
    '{8'h07, 8'h01, 12'h100, 12'hF00, 12'h7FF, 8'h00},
    '{8'h04, 8'h00, 12'h00A, 12'h3E7, 12'h3E7, 8'hA0},
    '{8'h01, 8'h00, 12'h000, 12'h000, 12'h100, 8'h00},
    '{8'h00, 8'h01, 12'h000, 12'h000, 12'h000, 8'h00}
  };

  // free-running core clock
  always #5 core_clk = ~core_clk;

  // count wake timer reset pulses
  always @(posedge core_clk) if (wake === 1'b1) wakes++;

  iwd_top iwd_top_i (
    .i_core_clk(core_clk), .i_nrst(nrst), .i_clk_en(clk_en),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sample_valid(sv),
    .i_x_data(xd), .i_y_data(yd), .i_z_data(zd),
    .o_interrupt_pin_a(pin_a), .o_interrupt_pin_b(pin_b),
    .o_wake_timer_reset(wake), .o_irq(irq)
  );

  iwd_host_model iwd_host_model_i (
    .i_core_clk(core_clk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one register access; a stuck bus ends the run
  task automatic acc(input logic w, input iwd_idx_t idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    bit ok;
    iwd_host_model_i.xfer(w, {idx, 2'b00}, {24'h0, wd}, rd, err, ok);
    if (!ok) begin
      fails++;
      $display("Error apb ready expected 1 seen 0");
      report_and_stop();
    end
  endtask

  task automatic wr(input iwd_idx_t idx, input logic [7:0] wd);
    logic [31:0] d;
    logic        e;
    acc(1'b1, idx, wd, d, e);
  endtask

  task automatic rdc(input string nm, input iwd_idx_t idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    acc(1'b0, idx, 8'h00, d, e);
    chk(nm, d, exp);
  endtask

  // n one-cycle sample strobes, one idle cycle between them
  task automatic smp(input logic [11:0] x, y, z, input int n);
    repeat (n) begin
      @(posedge core_clk);
      sv <= 1'b1;
      xd <= x;
      yd <= y;
      zd <= z;
      @(posedge core_clk);
      sv <= 1'b0;
    end
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic        e;
    int          w0;
    nrst = 1'b0;
    clk_en = 1'b1;
    sv = 1'b0;
    xd = 12'h000;
    yd = 12'h000;
    zd = 12'h000;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    wr(IDX_UPPER, 8'h10);
    wr(IDX_LOWER, 8'hF0);
    rdc("upper", IDX_UPPER, 32'h10);
    // table of window cases
    foreach (rows[i]) begin
      wr(IDX_CFG_A, rows[i].cfg_a);
      wr(IDX_CFG_B, rows[i].cfg_b);
      smp(rows[i].x, rows[i].y, rows[i].z, 1);
      rdc("status row", IDX_STATUS, {24'h0, rows[i].stat});
    end
    // debounce of three samples, idle cycles do not count
    wr(IDX_CFG_A, 8'h07);
    wr(IDX_CFG_B, 8'h00);
    smp(OUT, OUT, OUT, 1);
    wr(IDX_DBCNT, 8'h03);
    smp(IN, IN, IN, 2);
    rdc("debounce short", IDX_STATUS, 32'h00);
    smp(IN, IN, IN, 1);
    rdc("debounce met", IDX_STATUS, 32'hAA);
    // enable low: a false sample must not be taken
    clk_en <= 1'b0;
    smp(OUT, OUT, OUT, 1);
    clk_en <= 1'b1;
    rdc("frozen", IDX_STATUS, 32'hAA);
    smp(OUT, IN, IN, 1);
    rdc("flags held", IDX_STATUS, 32'h2A);
    smp(IN, IN, IN, 1);
    pause(10);
    smp(IN, IN, IN, 1);
    rdc("count restarted", IDX_STATUS, 32'h2A);
    smp(IN, IN, IN, 1);
    rdc("count met again", IDX_STATUS, 32'hAA);
    // latched flags, clear on read, rearm only after false
    wr(IDX_DBCNT, 8'h01);
    wr(IDX_CFG_A, 8'h47);
    smp(OUT, OUT, OUT, 1);
    smp(IN, IN, IN, 1);
    rdc("latched", IDX_STATUS, 32'hAA);
    rdc("cleared by read", IDX_STATUS, 32'h00);
    smp(IN, IN, IN, 2);
    rdc("no rearm", IDX_STATUS, 32'h00);
    smp(OUT, OUT, OUT, 1);
    smp(IN, IN, IN, 1);
    smp(OUT, OUT, OUT, 1);
    rdc("held past false", IDX_STATUS, 32'hAA);
    // wake pulses and pin routing
    wr(IDX_CFG_A, 8'h07);
    wr(IDX_DBCNT, 8'h00);
    wr(IDX_CFG_B, 8'h02);
    smp(OUT, OUT, OUT, 1);
    pause(3);
    w0 = wakes;
    smp(IN, IN, IN, 3);
    pause(3);
    chk("wake pulses", 32'(wakes - w0), 2);
    chk("pin a", 32'(pin_a), 1);
    chk("pin b", 32'(pin_b), 0);
    wr(IDX_CFG_B, 8'h06);
    pause(2);
    chk("pin b routed", 32'(pin_b), 1);
    chk("pin a routed", 32'(pin_a), 0);
    smp(OUT, OUT, OUT, 1);
    pause(3);
    w0 = wakes;
    smp(OUT, OUT, OUT, 2);
    pause(3);
    chk("no wake", 32'(wakes - w0), 0);
    chk("pin b idle", 32'(pin_b), 0);
    // interrupt raise, mask and clear
    wr(IDX_CFG_B, 8'h00);
    wr(IDX_IRQ_STAT, 8'h03);
    wr(IDX_IRQ_MASK, 8'h00);
    smp(IN, IN, IN, 1);
    pause(2);
    chk("irq masked", 32'(irq), 0);
    rdc("irq rise", IDX_IRQ_STAT, 32'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    pause(2);
    chk("irq on", 32'(irq), 1);
    wr(IDX_IRQ_STAT, 8'h01);
    pause(2);
    chk("irq cleared", 32'(irq), 0);
    smp(OUT, OUT, OUT, 1);
    rdc("irq fall", IDX_IRQ_STAT, 32'h02);
    chk("fall masked", 32'(irq), 0);
    wr(IDX_IRQ_MASK, 8'hFF);
    rdc("mask bits", IDX_IRQ_MASK, 32'h03);
    pause(2);
    chk("irq fall on", 32'(irq), 1);
    // writable bits only
    wr(IDX_CFG_A, 8'hFF);
    rdc("cfg a bits", IDX_CFG_A, 32'h47);
    wr(IDX_CFG_B, 8'hFF);
    rdc("cfg b bits", IDX_CFG_B, 32'h07);
    // raise pin b so the reset below has something to clear
    smp(IN, IN, IN, 1);
    pause(2);
    chk("pin b set", 32'(pin_b), 1);
    // reset in mid-run clears outputs and registers
    @(posedge core_clk);
    nrst <= 1'b0;
    pause(2);
    chk("irq in reset", 32'(irq), 0);
    chk("pin b in reset", 32'(pin_b), 0);
    @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 46; i <= 53; i++) begin
      rdc("reset value", iwd_idx_t'(i), 32'h0);
    end
    wr(IDX_STATUS, 8'hFF);
    rdc("status read only", IDX_STATUS, 32'h0);
    acc(1'b0, 6'h3F, 8'h00, d, e);
    chk("unmapped err", 32'(e), 1);
    chk("unmapped data", d, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
